// [src/flash_option_regs.svh]
`ifndef FLASH_OPTION_REGS_SVH
`define FLASH_OPTION_REGS_SVH

// Special function register addresses on the core's register port
`define OPT_INDEX_ADDR 8'hfe
`define OPT_DATA_ADDR 8'hff
// Index of the configuration word behind the data port
`define OPT_WORD_ONE_INDEX 8'hc2
`define OPT_INDEX_RESET 8'h00

// Field positions inside the configuration word
`define OPT_ADC_REF_MSB 7
`define OPT_ADC_REF_LSB 6
`define OPT_BOOT_BIT 5
`define OPT_DEBUG_BIT 4
`define OPT_RANGE_MSB 3
`define OPT_RANGE_LSB 2
`define OPT_LOADER_MSB 1
`define OPT_LOADER_LSB 0
// Loader size bits cannot be changed by software
`define OPT_WRITE_MASK 8'hfc

// Flash geometry
`define FLASH_TOP 15'h7fff
`define PROTECTED_HEAD_LAST 15'h00ff
`define APP_TOP_NONE 15'h7fff
`define APP_TOP_1K 15'h7bff
`define APP_TOP_2K 15'h77ff
`define APP_TOP_4K 15'h6fff
`define WINDOW_START_1K 15'h7c00
`define WINDOW_START_2K 15'h7800
// Reset vectors: application start and loader partition bases
`define APP_BASE 15'h0000
`define LOADER_BASE_1K 15'h7c00
`define LOADER_BASE_2K 15'h7800
`define LOADER_BASE_4K 15'h7000

`endif

// [src/flash_option_pkg.sv]
package flash_option_pkg;

	typedef enum logic [1:0] {
		ref_supply = 2'b00,
		ref_2v4 = 2'b01,
		ref_1v024 = 2'b10,
		ref_2v048 = 2'b11
	} adc_ref_type;

	typedef enum logic [1:0] {
		range_none = 2'b00,
		range_last_1k = 2'b01,
		range_last_2k = 2'b10,
		range_all = 2'b11
	} range_type;

	typedef enum logic [1:0] {
		loader_none = 2'b00,
		loader_1k = 2'b01,
		loader_2k = 2'b10,
		loader_4k = 2'b11
	} loader_size_type;

	typedef struct packed {
		adc_ref_type adc_reference_select;
		logic boot_area_select;
		logic debug_pin_release;
		range_type self_program_range;
		loader_size_type loader_partition_size;
	} option_word_type;

	typedef struct packed {
		logic valid;
		logic is_program;
		logic [14:0] addr;
		logic [7:0] wdata;
	} flash_req_type;

	typedef struct packed {
		logic allowed;
		logic target_loader;
	} access_verdict_type;

endpackage

// [src/flash_access_check.sv]
`timescale 1ns/1ps
`include "flash_option_regs.svh"

module flash_access_check (
	// Settings
	input wire flash_option_pkg::option_word_type opt,
	// Request under test
	input wire flash_option_pkg::flash_req_type req,
	// Verdict
	output flash_option_pkg::access_verdict_type verdict
);
	import flash_option_pkg::*;

	logic [14:0] app_top;
	logic in_loader;
	logic in_window;

	always_comb begin
		unique case (opt.loader_partition_size)
			loader_none: app_top = `APP_TOP_NONE;
			loader_1k: app_top = `APP_TOP_1K;
			loader_2k: app_top = `APP_TOP_2K;
			loader_4k: app_top = `APP_TOP_4K;
		endcase
	end

	// Boundary follows the partition size, not a fixed address
	assign in_loader = (req.addr > app_top); // see R09 see R12

	always_comb begin
		unique case (opt.self_program_range)
			range_none: in_window = 1'b0;
			range_last_1k: in_window = (req.addr >= `WINDOW_START_1K);
			range_last_2k: in_window = (req.addr >= `WINDOW_START_2K);
			range_all: in_window = 1'b1;
		endcase // see R06
	end

	always_comb begin
		verdict.target_loader = in_loader;
		if (req.is_program) begin
			if (in_loader) begin
				verdict.allowed = 1'b0; // see R08
			end else if (opt.boot_area_select) begin
				verdict.allowed = 1'b1; // see R04 see R07
			end else begin
				verdict.allowed = in_window; // see R03
			end
		end else begin
			if (opt.boot_area_select) begin
				verdict.allowed = 1'b1; // see R04
			end else begin
				verdict.allowed = !in_loader && (req.addr > `PROTECTED_HEAD_LAST); // see R03
			end
		end
	end

endmodule // flash_access_check

// [src/flash_partition_option_control.sv]
// What this block does
// R01: Two-bit field selects ADC reference: supply, 2.4V, 1.024V or 2.048V.
// R02: Boot select bit 5 chooses application or loader flash after reset.
// R03: Application boot blocks loader access and table reads of first 256 bytes.
// R04: Loader boot allows all table reads and all application programming.
// R05: Debug release zero keeps shared pins as debug clock and data.
// R06: Range field: none, last 1K, last 2K or whole flash programmable.
// R07: Range window ignored while executing from loader flash.
// R08: Programming inside loader flash is always rejected.
// R09: Loader size field carves 0, 1K, 2K or 4K from flash top.
// R10: Option word reached through index register FEH and data register FFH.
// R11: Option word loaded from programmed flash area on each reset.
// R12: Requests checked against partition boundary; rejects change and return nothing.
`timescale 1ns/1ps
`include "flash_option_regs.svh"

module flash_partition_option_control (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Programmed option byte from the option flash area
	input wire logic [7:0] stored_option,
	input wire logic stored_option_valid,
	// Core register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Core flash requests
	input wire flash_option_pkg::flash_req_type core_req,
	output logic core_rvalid,
	output logic [7:0] core_rdata,
	output logic core_reject,
	// Flash array
	output logic flash_rd,
	output logic flash_wr,
	output logic [14:0] flash_addr,
	output logic [7:0] flash_wdata,
	input wire logic [7:0] flash_q,
	// Settings to the rest of the chip
	output flash_option_pkg::adc_ref_type adc_reference_select,
	output logic boot_from_loader,
	output logic debug_port_active,
	output logic [14:0] reset_vector,
	output logic loading
);
	import flash_option_pkg::*;

	typedef enum logic [1:0] {
		st_load = 2'b00,
		st_run = 2'b01
	} load_state_type;

	load_state_type state_q;
	logic [7:0] index_q;
	logic [7:0] word_q;
	logic boot_q;
	logic rd_pend_q;
	logic [1:0] valid_sync_q;
	option_word_type opt;
	access_verdict_type verdict;
	logic req_ok;
	logic [14:0] vector_q;
	logic debug_active_q;
	logic load_now;
	loader_size_type stored_size;

	assign opt = option_word_type'(word_q);
	assign load_now = (state_q == st_load) && valid_sync_q[1];
	assign stored_size = loader_size_type'(stored_option[`OPT_LOADER_MSB:`OPT_LOADER_LSB]);

	// Valid strobe comes from the option flash's own timing, so sync it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			valid_sync_q <= 2'b00;
		end else begin
			valid_sync_q <= {valid_sync_q[0], stored_option_valid};
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= st_load;
		end else begin
			unique case (state_q)
				st_load: if (valid_sync_q[1]) state_q <= st_run; // see R11
				st_run: state_q <= st_run;
				default: state_q <= st_load;
			endcase
		end
	end

	function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] ref_addr);
		sfr_hit = (a == ref_addr);
	endfunction

	// Base of the loader partition, or the application start when none is carved out
	function automatic logic [14:0] loader_base(input loader_size_type sz);
		unique case (sz)
			loader_none: loader_base = `APP_BASE;
			loader_1k: loader_base = `LOADER_BASE_1K;
			loader_2k: loader_base = `LOADER_BASE_2K;
			loader_4k: loader_base = `LOADER_BASE_4K;
		endcase
	endfunction

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			index_q <= `OPT_INDEX_RESET;
		end else if (sfr_wr && sfr_hit(sfr_addr, `OPT_INDEX_ADDR)) begin
			index_q <= sfr_wdata; // see R10
		end
	end

	// Stored byte is sampled only after the synchronised valid, so it is stable
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			word_q <= 8'h00;
		end else if (state_q == st_load) begin
			if (valid_sync_q[1]) begin
				word_q <= stored_option; // see R11
			end
		end else if (sfr_wr && sfr_hit(sfr_addr, `OPT_DATA_ADDR)
			&& index_q == `OPT_WORD_ONE_INDEX) begin
			word_q <= (sfr_wdata & `OPT_WRITE_MASK) | (word_q & ~`OPT_WRITE_MASK); // see R10
		end
	end

	// Boot region is latched at load from the stored byte; later writes to the word never reach it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			boot_q <= 1'b0;
		end else if (load_now) begin
			boot_q <= stored_option[`OPT_BOOT_BIT]; // see R02
		end
	end

	// Vector is fixed at load, like the boot region it follows
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			vector_q <= `APP_BASE;
		end else if (load_now) begin
			if (stored_option[`OPT_BOOT_BIT]) begin
				vector_q <= loader_base(stored_size); // see R02 see R09
			end else begin
				vector_q <= `APP_BASE; // see R02
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			if (sfr_hit(sfr_addr, `OPT_INDEX_ADDR)) begin
				sfr_rdata <= index_q;
			end else if (sfr_hit(sfr_addr, `OPT_DATA_ADDR) && index_q == `OPT_WORD_ONE_INDEX) begin
				sfr_rdata <= word_q; // see R10
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

	// Checks use the boot region captured at reset, not the live bit
	flash_access_check u_check (
		.opt({opt.adc_reference_select, boot_q, opt.debug_pin_release,
			opt.self_program_range, opt.loader_partition_size}),
		.req(core_req),
		.verdict(verdict)
	);

	assign req_ok = core_req.valid && (state_q == st_run) && verdict.allowed; // see R12

	assign flash_rd = req_ok && !core_req.is_program;
	// Loader flag gates writes again so a window decode slip never reaches the loader
	assign flash_wr = req_ok && core_req.is_program && !verdict.target_loader; // see R08 see R12
	assign flash_addr = core_req.addr;
	assign flash_wdata = core_req.wdata;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_pend_q <= 1'b0;
		end else begin
			rd_pend_q <= flash_rd;
		end
	end

	// Requests before the settings are loaded are dropped, not refused
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_reject <= 1'b0;
		end else begin
			core_reject <= core_req.valid && (state_q == st_run) && !verdict.allowed; // see R12
		end
	end

	// Refused reads never expose array data
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_rdata <= 8'h00;
			core_rvalid <= 1'b0;
		end else begin
			core_rvalid <= rd_pend_q;
			core_rdata <= rd_pend_q ? flash_q : 8'h00; // see R12
		end
	end

	assign adc_reference_select = opt.adc_reference_select; // see R01
	assign boot_from_loader = boot_q; // see R02
	assign debug_port_active = debug_active_q;
	assign reset_vector = vector_q;

	// Pin mux select comes from a flop so it cannot glitch while the word is rewritten
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			debug_active_q <= 1'b1;
		end else begin
			debug_active_q <= !opt.debug_pin_release; // see R05
		end
	end

	assign loading = (state_q == st_load);

endmodule // flash_partition_option_control

// [verification/flash_model.sv]
`timescale 1ns/1ps
module flash_model (
	// Clock
	input wire logic clk_sys,
	// Array port
	input wire logic flash_rd,
	input wire logic flash_wr,
	input wire logic [14:0] flash_addr,
	input wire logic [7:0] flash_wdata,
	output logic [7:0] flash_q
);
	logic [7:0] mem [0:32767];
	initial begin
		for (int i = 0; i < 32768; i++) begin
			mem[i] = i[7:0] ^ 8'h5a;
		end
		flash_q = 8'h00;
	end
	// Data holds only the cycle after a read; it drifts after so stale use shows
	always @(posedge clk_sys) begin
		if (flash_wr) begin
			mem[flash_addr] <= flash_wdata;
		end
		flash_q <= flash_rd ? mem[flash_addr] : ~flash_q;
	end
endmodule // flash_model

// [verification/flash_option_asserts.sv]
`timescale 1ns/1ps
module flash_option_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Core and array side
	input wire flash_option_pkg::flash_req_type core_req,
	input wire logic core_rvalid,
	input wire logic core_reject,
	input wire logic flash_rd,
	input wire logic flash_wr,
	input wire logic [14:0] flash_addr,
	input wire logic boot_from_loader,
	input wire logic [14:0] reset_vector,
	input wire logic loading
);
	import flash_option_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic strobe;
	assign strobe = flash_rd | flash_wr;
	read_answer_a: assert property (flash_rd |=> ##1 core_rvalid)
		else $error("read answer missing");
	refuse_pulse_a: assert property (core_req.valid && !loading && !strobe |=> core_reject)
		else $error("refusal not flagged");
	load_quiet_a: assert property (loading |-> !strobe)
		else $error("strobe while loading");
	strobe_addr_a: assert property (strobe |-> core_req.valid && flash_addr == core_req.addr)
		else $error("strobe without request");
	strobe_kind_a: assert property (strobe |-> flash_wr == core_req.is_program)
		else $error("wrong strobe kind");
	head_guard_a: assert property (flash_rd && !boot_from_loader |-> core_req.addr > 15'h00ff)
		else $error("head read let through");
	app_vector_a: assert property (!boot_from_loader |-> reset_vector == 15'h0000)
		else $error("vector not zero");
	loader_write_a: assert property (flash_wr && reset_vector != 15'h0000 |-> core_req.addr < reset_vector)
		else $error("loader write let through");
	cover property (flash_wr);
	cover property (core_reject);
	cover property (core_rvalid && boot_from_loader);
endmodule // flash_option_asserts

bind flash_partition_option_control flash_option_asserts u_chk (.clk_sys, .rst, .core_req,
	.core_rvalid, .core_reject, .flash_rd, .flash_wr, .flash_addr, .boot_from_loader,
	.reset_vector, .loading);

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import flash_option_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic stored_option_valid = 1'b0;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] stored_option = 8'h00;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	flash_req_type core_req = '0;
	logic core_rvalid, core_reject, flash_rd, flash_wr, boot_from_loader, debug_port_active, loading;
	logic [7:0] sfr_rdata, core_rdata, flash_wdata, flash_q;
	logic [14:0] flash_addr, reset_vector;
	adc_ref_type adc_reference_select;
	int n_mismatch = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [7:0] image [0:32767];
	always #20 clk_sys = ~clk_sys;
	flash_partition_option_control u_dut (.clk_sys, .rst, .stored_option, .stored_option_valid,
		.sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .core_req, .core_rvalid, .core_rdata,
		.core_reject, .flash_rd, .flash_wr, .flash_addr, .flash_wdata, .flash_q,
		.adc_reference_select, .boot_from_loader, .debug_port_active, .reset_vector, .loading);
	flash_model u_flash (.clk_sys, .flash_rd, .flash_wr, .flash_addr, .flash_wdata, .flash_q);
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task print_verdict;
		$display("tests %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Boot region is only captured at load, so each region needs its own reset
	task boot(input logic [7:0] o);
		rst = 1'b1;
		stored_option = o;
		stored_option_valid = 1'b1;
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		repeat (8) @(negedge clk_sys);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk_sys);
		sfr_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk_sys);
		sfr_rd = 1'b0;
		check("option", sfr_rdata, exp);
	endtask
	task req(input logic p, input logic [14:0] a, input logic ok);
		@(negedge clk_sys);
		core_req = '{1'b1, p, a, 8'h3c};
		#1;
		check("strobe", flash_rd | flash_wr, ok);
		@(posedge clk_sys);
		#1;
		check("reject", core_reject, !ok);
		if (ok && p) begin
			image[a] = 8'h3c;
		end
		@(negedge clk_sys);
		core_req.valid = 1'b0;
		if (ok && !p) begin
			@(posedge clk_sys);
			#1;
			check("rdata", {core_rvalid, core_rdata}, {1'b1, image[a]});
		end
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		for (int i = 0; i < 32768; i++) begin
			image[i] = i[7:0] ^ 8'h5a;
		end
		boot(8'h46);
		check("loading", loading, 0);
		check("adc", adc_reference_select, ref_2v4);
		check("boot", boot_from_loader, 0);
		check("debug", debug_port_active, 1);
		wr(8'hfe, 8'hc2);
		rd(8'hff, 8'h46);
		wr(8'hff, 8'h8b);
		rd(8'hff, 8'h8a);
		check("adc", adc_reference_select, ref_1v024);
		wr(8'hff, 8'hcd);
		rd(8'hff, 8'hce);
		check("adc", adc_reference_select, ref_2v048);
		req(0, 15'h0080, 0);
		req(0, 15'h0100, 1);
		req(0, 15'h7900, 0);
		req(1, 15'h0010, 1);
		req(1, 15'h7800, 0);
		wr(8'hff, 8'h46);
		req(1, 15'h7000, 0);
		wr(8'hff, 8'h42);
		req(1, 15'h0010, 0);
		wr(8'hfe, 8'hc1);
		rd(8'hfe, 8'hc1);
		rd(8'hff, 8'h00);
		boot(8'h33);
		check("boot", boot_from_loader, 1);
		check("vector", reset_vector, 15'h7000);
		check("debug", debug_port_active, 0);
		check("adc", adc_reference_select, ref_supply);
		req(1, 15'h0020, 1);
		req(0, 15'h0020, 1);
		req(1, 15'h7000, 0);
		req(0, 15'h7000, 1);
		req(0, 15'h0000, 1);
		// No loader carved out, so the range windows can be seen granting writes
		boot(8'h04);
		check("vector", reset_vector, 15'h0000);
		req(1, 15'h7c00, 1);
		req(1, 15'h7bff, 0);
		req(0, 15'h7c00, 1);
		wr(8'hfe, 8'hc2);
		wr(8'hff, 8'h08);
		req(1, 15'h7800, 1);
		req(1, 15'h77ff, 0);
		print_verdict();
	end
endmodule // tb_top
